// ### hw/ipr_regs_top.sv
// Interrupt priority registers 0 to 3 with per-level request forwarding.
// Assumes a single-cycle register port, synchronous source requests and a core that
// samples one request line per priority level.
// Operation
// - Unused bits read zero, ignore writes
// - Debug fields: off, levels one to three
// - Peripheral fields: off, levels zero to two
// - All fields reset to off
// - Register a: breakpoint, step counter fields
// - Register b: receive, transmit, trace fields
// - System register: three flash fields on top
// - System register: lock loss, low voltage
// - System register: external pins b, a
// - Port register: ports d, e, f
// - Port register: message, wake, error, bus-off fields
module ipr_regs_top (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [ipr_pkg::ADDR_W-1:0] addr_in,
    input wire logic [ipr_pkg::DATA_W-1:0] wr_data_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    output logic [ipr_pkg::DATA_W-1:0] rd_data_out,
    input wire logic [ipr_pkg::SRC_NUM-1:0] src_req_in,
    output logic [3:0] level_req_out
);

    // ********************************************************
    // State and per-source decode
    // ********************************************************
    ipr_pkg::ipr_state_t state_q;
    ipr_pkg::ipr_state_t state_d;
    logic addr_hit;
    logic [1:0] reg_sel;
    logic [1:0] src_field [ipr_pkg::SRC_NUM];
    logic [1:0] src_lvl [ipr_pkg::SRC_NUM];
    logic [ipr_pkg::SRC_NUM-1:0] src_en;

    // Only offsets 0..3 belong to this block
    assign addr_hit = (addr_in < ipr_pkg::ADDR_W'(ipr_pkg::REG_NUM));
    assign reg_sel = addr_in[1:0];

    // Each source picks its field out of the register array
    for (genvar i = 0; i < ipr_pkg::SRC_NUM; i++) begin : g_src
        assign src_field[i] = state_q.regs[ipr_pkg::SRC_REG[i]][ipr_pkg::SRC_POS[i] +: 2];
        ipr_level_dec #(
            .DEBUG_SRC(i < ipr_pkg::SRC_DEBUG_NUM)
        ) u_dec (
            .field_in(src_field[i]),
            .en_out(src_en[i]),
            .level_out(src_lvl[i])
        );

        // Decoded level follows field exactly, per source class
        if (i < ipr_pkg::SRC_DEBUG_NUM) begin : g_dbg
            chk_debug_level_map: assert property (
                @(posedge clk_in) disable iff (rst_in)
                src_en[i] |-> (src_lvl[i] == src_field[i]) && (src_lvl[i] != 2'h0)
            ) else $error("debug source level decode wrong");
        end else begin : g_per
            chk_periph_level_map: assert property (
                @(posedge clk_in) disable iff (rst_in)
                src_en[i] |-> (src_lvl[i] == src_field[i] - 2'h1) && (src_lvl[i] != 2'h3)
            ) else $error("peripheral source level decode wrong");
        end

        // A write lands in the documented field of the selected register
        chk_field_place_write: assert property (
            @(posedge clk_in) disable iff (rst_in)
            (ce_in && wr_en_in && addr_in == ipr_pkg::ADDR_W'(ipr_pkg::SRC_REG[i]))
            |=> (src_field[i] == $past(wr_data_in[ipr_pkg::SRC_POS[i] +: 2]))
        ) else $error("priority field not at its bit position");

        // An enabled, requesting source shows on its level line one cycle later
        chk_forward_level: assert property (
            @(posedge clk_in) disable iff (rst_in)
            (ce_in && src_req_in[i] && src_en[i]) |=> level_req_out[$past(src_lvl[i])]
        ) else $error("enabled request not forwarded at its level");
    end

    // ********************************************************
    // Next-state logic
    // ********************************************************

    // Reads return last cycle's contents; rdata is zero outside a read reply
    always_comb begin
        state_d = state_q;
        state_d.rdata = 16'h0000;
        state_d.level_req = 4'h0;
        if (wr_en_in && addr_hit) begin
            state_d.regs[reg_sel] = wr_data_in & ipr_pkg::REG_MASK[reg_sel];
        end
        if (rd_en_in && addr_hit) begin
            state_d.rdata = state_q.regs[reg_sel];
        end
        // Field value 00 keeps a source off every level line
        for (int i = 0; i < ipr_pkg::SRC_NUM; i++) begin
            if (src_req_in[i] && src_en[i]) begin
                state_d.level_req[src_lvl[i]] = 1'b1;
            end
        end
    end

    // ********************************************************
    // State register
    // ********************************************************

    // Reset wins over the clock enable so a frozen block still clears
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_q <= ipr_pkg::STATE_RESET;
        end else if (ce_in) begin
            state_q <= state_d;
        end
    end

    assign rd_data_out = state_q.rdata;
    assign level_req_out = state_q.level_req;

    // ********************************************************
    // Register port checks
    // ********************************************************

    // Unused bits of each register read back as zero
    chk_reserved_read_a: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && rd_en_in && addr_in == ipr_pkg::DEBUG_IRQ_LEVEL_REG_A_OFS)
        |=> ((rd_data_out & ~ipr_pkg::DEBUG_A_MASK) == 16'h0000)
    ) else $error("reserved bits of debug register a not zero");

    chk_reserved_read_b: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && rd_en_in && addr_in == ipr_pkg::DEBUG_IRQ_LEVEL_REG_B_OFS)
        |=> ((rd_data_out & ~ipr_pkg::DEBUG_B_MASK) == 16'h0000)
    ) else $error("reserved bits of debug register b not zero");

    chk_reserved_read_sys: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && rd_en_in && addr_in == ipr_pkg::SYSTEM_IRQ_LEVEL_REG_OFS)
        |=> ((rd_data_out & ~ipr_pkg::SYSTEM_MASK) == 16'h0000)
    ) else $error("reserved bits of system register not zero");

    chk_reserved_read_port: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && rd_en_in && addr_in == ipr_pkg::PORT_CAN_IRQ_LEVEL_REG_OFS)
        |=> ((rd_data_out & ~ipr_pkg::PORT_CAN_MASK) == 16'h0000)
    ) else $error("reserved bits of port register not zero");

    // Write then read of the same register returns the masked write data
    chk_write_readback: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && wr_en_in && addr_hit)
        ##1 (ce_in && rd_en_in && !wr_en_in && addr_in == $past(addr_in))
        |=> (rd_data_out == ($past(wr_data_in, 2) & ipr_pkg::REG_MASK[$past(reg_sel, 2)]))
    ) else $error("read back differs from masked write");

    // Unmapped offsets answer zero
    chk_unmapped_zero: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && rd_en_in && !addr_hit) |=> (rd_data_out == 16'h0000)
    ) else $error("unmapped read not zero");

    // Read data stands for exactly one enabled cycle
    chk_rdata_one_cycle: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && !rd_en_in) |=> (rd_data_out == 16'h0000)
    ) else $error("read data outside its reply cycle");

    // ********************************************************
    // Reset and request checks
    // ********************************************************

    // Every field is off right after reset, and nothing is forwarded
    chk_reset_all_off: assert property (
        @(posedge clk_in)
        rst_in |=> (src_en == '0) && (level_req_out == 4'h0) && (rd_data_out == 16'h0000)
    ) else $error("fields not off after reset");

    // No request in means no level line out
    chk_idle_no_level: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && src_req_in == '0) |=> (level_req_out == 4'h0)
    ) else $error("level line raised without a request");

    // Requests from disabled sources are suppressed
    chk_disabled_suppress: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && (src_req_in & src_en) == '0) |=> (level_req_out == 4'h0)
    ) else $error("disabled source reached the core");

    // Debug sources alone never raise level zero
    chk_debug_no_level0: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && (src_req_in & src_en) == ({{(ipr_pkg::SRC_NUM - ipr_pkg::SRC_DEBUG_NUM){1'b0}},
            {ipr_pkg::SRC_DEBUG_NUM{1'b1}}} & src_req_in & src_en)) |=> !level_req_out[0]
    ) else $error("debug source raised level zero");

    // Peripheral sources alone never raise level three
    chk_periph_no_level3: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (ce_in && (src_req_in & src_en & {{(ipr_pkg::SRC_NUM - ipr_pkg::SRC_DEBUG_NUM){1'b0}},
            {ipr_pkg::SRC_DEBUG_NUM{1'b1}}}) == '0) |=> !level_req_out[3]
    ) else $error("peripheral source raised level three");

    // Clock enable low freezes everything the block shows
    chk_ce_freeze: assert property (
        @(posedge clk_in) disable iff (rst_in)
        !ce_in |=> $stable(rd_data_out) && $stable(level_req_out) && $stable(src_en)
    ) else $error("state moved while clock enable low");

endmodule

// ### hw/ipr_pkg.sv
// Constants and types shared by the priority register block and its decoder.
// Assumes a 16-bit register port addressed by word offset from the controller base.
package ipr_pkg;

    // ********************************************************
    // Bus geometry and register offsets
    // ********************************************************
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int REG_NUM = 4;
    localparam logic [4:0] DEBUG_IRQ_LEVEL_REG_A_OFS = 5'h00;
    localparam logic [4:0] DEBUG_IRQ_LEVEL_REG_B_OFS = 5'h01;
    localparam logic [4:0] SYSTEM_IRQ_LEVEL_REG_OFS = 5'h02;
    localparam logic [4:0] PORT_CAN_IRQ_LEVEL_REG_OFS = 5'h03;

    // ********************************************************
    // Implemented bits per register and reset value
    // ********************************************************
    localparam logic [15:0] DEBUG_A_MASK = 16'h3c00;
    localparam logic [15:0] DEBUG_B_MASK = 16'h003f;
    localparam logic [15:0] SYSTEM_MASK = 16'hffcf;
    localparam logic [15:0] PORT_CAN_MASK = 16'hfffc;
    localparam logic [15:0] REG_MASK [REG_NUM] = '{DEBUG_A_MASK, DEBUG_B_MASK, SYSTEM_MASK, PORT_CAN_MASK};
    localparam logic [15:0] REG_RESET = 16'h0000;

    // ********************************************************
    // Field encoding
    // ********************************************************
    localparam logic [1:0] FIELD_OFF = 2'b00;
    localparam logic [1:0] PERIPH_LEVEL_SHIFT = 2'b01;

    // ********************************************************
    // Field positions (low bit of each 2-bit field)
    // ********************************************************
    localparam int BREAKPOINT0_LEVEL_POS = 12;
    localparam int STEP_COUNTER_LEVEL_POS = 10;
    localparam int DEBUG_RX_FULL_LEVEL_POS = 4;
    localparam int DEBUG_TX_EMPTY_LEVEL_POS = 2;
    localparam int TRACE_BUFFER_LEVEL_POS = 0;
    localparam int FLASH_BUFFERS_EMPTY_LEVEL_POS = 14;
    localparam int FLASH_CMD_DONE_LEVEL_POS = 12;
    localparam int FLASH_ERROR_LEVEL_POS = 10;
    localparam int PLL_LOCK_LOSS_LEVEL_POS = 8;
    localparam int LOW_VOLTAGE_LEVEL_POS = 6;
    localparam int EXT_PIN_B_LEVEL_POS = 2;
    localparam int EXT_PIN_A_LEVEL_POS = 0;
    localparam int PORT_D_LEVEL_POS = 14;
    localparam int PORT_E_LEVEL_POS = 12;
    localparam int PORT_F_LEVEL_POS = 10;
    localparam int CAN_MSGBUF_LEVEL_POS = 8;
    localparam int CAN_WAKE_LEVEL_POS = 6;
    localparam int CAN_ERROR_LEVEL_POS = 4;
    localparam int CAN_BUS_OFF_LEVEL_POS = 2;

    // ********************************************************
    // Source table: debug sources first, then peripherals
    // ********************************************************
    localparam int SRC_NUM = 19;
    localparam int SRC_DEBUG_NUM = 5;
    localparam logic [1:0] SRC_REG [SRC_NUM] = '{
        2'h0, 2'h0,
        2'h1, 2'h1, 2'h1,
        2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2,
        2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3
    };
    localparam int SRC_POS [SRC_NUM] = '{
        BREAKPOINT0_LEVEL_POS, STEP_COUNTER_LEVEL_POS,
        DEBUG_RX_FULL_LEVEL_POS, DEBUG_TX_EMPTY_LEVEL_POS, TRACE_BUFFER_LEVEL_POS,
        FLASH_BUFFERS_EMPTY_LEVEL_POS, FLASH_CMD_DONE_LEVEL_POS, FLASH_ERROR_LEVEL_POS,
        PLL_LOCK_LOSS_LEVEL_POS, LOW_VOLTAGE_LEVEL_POS, EXT_PIN_B_LEVEL_POS, EXT_PIN_A_LEVEL_POS,
        PORT_D_LEVEL_POS, PORT_E_LEVEL_POS, PORT_F_LEVEL_POS,
        CAN_MSGBUF_LEVEL_POS, CAN_WAKE_LEVEL_POS, CAN_ERROR_LEVEL_POS, CAN_BUS_OFF_LEVEL_POS
    };

    // ********************************************************
    // Block state
    // ********************************************************
    typedef struct packed {
        logic [REG_NUM-1:0][DATA_W-1:0] regs;
        logic [DATA_W-1:0] rdata;
        logic [3:0] level_req;
    } ipr_state_t;

    localparam ipr_state_t STATE_RESET = '{regs: {REG_NUM{REG_RESET}}, rdata: 16'h0000, level_req: 4'h0};

endpackage

// ### hw/ipr_level_dec.sv
// Decoder from one 2-bit priority field to an enable and a core level.
// Assumes the field comes straight from a register; purely combinational.
module ipr_level_dec #(
    parameter bit DEBUG_SRC = 1'b0
) (
    input wire logic [1:0] field_in,
    output logic en_out,
    output logic [1:0] level_out
);

    // ********************************************************
    // Field decode
    // ********************************************************

    // Debug sources map 1..3, peripherals 0..2; off forces level 0
    always_comb begin
        en_out = (field_in != ipr_pkg::FIELD_OFF);
        level_out = 2'h0;
        if (en_out) begin
            if (DEBUG_SRC) begin
                level_out = field_in;
            end else begin
                level_out = field_in - ipr_pkg::PERIPH_LEVEL_SHIFT;
            end
        end
    end

endmodule

// ### verification/ipr_core_model.sv
// Behavioural model of the core's interrupt request input.
// Assumes one request line per priority level, sampled on the block clock.
module ipr_core_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [3:0] level_req_in,
    output logic [2:0] top_level_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // ********************************************************
    // Highest requested level, registered
    // ********************************************************
    // Bit 2 flags a request; a plain priority pick, no masking by the core
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            top_level_out <= 3'h0;
        end else begin
            top_level_out <= 3'h0;
            for (int k = 0; k < 4; k++) begin
                if (level_req_in[k]) begin
                    top_level_out <= {1'b1, 2'(k)};
                end
            end
        end
    end
endmodule

// ### verification/tb.sv
// Self-checking bench for the priority register block.
// Assumes the core model beside it and a register port with one-cycle read data.
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_in, rst_in, ce_in, wr_en_in, rd_en_in;
    logic [ipr_pkg::ADDR_W-1:0] addr_in;
    logic [ipr_pkg::DATA_W-1:0] wr_data_in, rd_data_out;
    logic [ipr_pkg::SRC_NUM-1:0] src_req_in;
    logic [3:0] level_req_out;
    logic [2:0] top_level;
    logic [15:0] regs_m [4];
    logic [15:0] d;
    int a, failures, check_count;
    // Register and low bit of every source field, in request index order
    int src_reg [19] = '{0, 0, 1, 1, 1, 2, 2, 2, 2, 2, 2, 2, 3, 3, 3, 3, 3, 3, 3};
    int src_pos [19] = '{12, 10, 4, 2, 0, 14, 12, 10, 8, 6, 2, 0, 14, 12, 10, 8, 6, 4, 2};

    ipr_regs_top u_dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
        .src_req_in(src_req_in), .level_req_out(level_req_out));
    ipr_core_model u_core (.clk_in(clk_in), .rst_in(rst_in), .level_req_in(level_req_out),
        .top_level_out(top_level));

    // ********************************************************
    // Expectations
    // ********************************************************
    // Writable bits per offset; unmapped offsets hold nothing
    function automatic logic [15:0] mask_of(input int r);
        case (r)
            0: return 16'h3c00;
            1: return 16'h003f;
            2: return 16'hffcf;
            3: return 16'hfffc;
            default: return 16'h0000;
        endcase
    endfunction

    // Debug sources start at level one, peripherals at level zero
    function automatic logic [3:0] lvl_of(input int src, input logic [1:0] code);
        if (code == 2'h0) return 4'h0;
        if (src < 5) return 4'h1 << code;
        return 4'h1 << (code - 2'h1);
    endfunction

    function automatic logic [3:0] exp_levels(input logic [18:0] req);
        logic [3:0] acc;
        acc = 4'h0;
        for (int i = 0; i < 19; i++) begin
            if (req[i]) acc |= lvl_of(i, 2'(regs_m[src_reg[i]] >> src_pos[i]));
        end
        return acc;
    endfunction

    function automatic logic [2:0] top_of(input logic [3:0] l);
        for (int k = 3; k >= 0; k--) begin
            if (l[k]) return {1'b1, 2'(k)};
        end
        return 3'h0;
    endfunction

    // ********************************************************
    // Checking and bus tasks
    // ********************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic wr(input int r, input logic [15:0] v);
        @(posedge clk_in);
        wr_en_in <= 1'b1;
        addr_in <= 5'(r);
        wr_data_in <= v;
        @(posedge clk_in);
        wr_en_in <= 1'b0;
        if (r < 4) regs_m[r] = v & mask_of(r);
    endtask

    // Data stands only in the cycle after the strobe, then drops to zero
    task automatic rd(input int r, input logic [15:0] exp);
        @(posedge clk_in);
        rd_en_in <= 1'b1;
        addr_in <= 5'(r);
        @(posedge clk_in);
        rd_en_in <= 1'b0;
        #1;
        check(rd_data_out, exp);
        @(posedge clk_in);
        #1;
        check(rd_data_out, 16'h0000);
    endtask

    // ********************************************************
    // Clock, watchdog and main sequence
    // ********************************************************
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end

    // Whole run needs under a thousand cycles; this bound is far past it
    initial begin
        repeat (20000) @(posedge clk_in);
        failures++;
        final_report();
    end

    initial begin
        rst_in = 1'b1;
        ce_in = 1'b1;
        wr_en_in = 1'b0;
        rd_en_in = 1'b0;
        addr_in = 5'h00;
        wr_data_in = 16'h0000;
        src_req_in = 19'h00000;
        failures = 0;
        check_count = 0;
        for (int r = 0; r < 4; r++) regs_m[r] = 16'h0000;
        void'($urandom(91157));
        repeat (16) @(posedge clk_in);
        rst_in <= 1'b0;
        // Everything starts off after reset
        for (int r = 0; r < 4; r++) rd(r, 16'h0000);
        src_req_in <= 19'h7ffff;
        repeat (2) @(posedge clk_in);
        #1;
        check({12'h000, level_req_out}, 16'h0000);
        // Every source, every code, alone in its register
        for (int i = 0; i < 19; i++) begin
            for (int c = 0; c < 4; c++) begin
                wr(src_reg[i], 16'(c) << src_pos[i]);
                src_req_in <= 19'h00001 << i;
                repeat (2) @(posedge clk_in);
                #1;
                check({12'h000, level_req_out}, {12'h000, lvl_of(i, 2'(c))});
                @(posedge clk_in);
                #1;
                check({13'h0000, top_level}, {13'h0000, top_of(lvl_of(i, 2'(c)))});
            end
        end
        // Random contents, unmapped offsets and request mixes
        repeat (60) begin
            a = $urandom_range(5, 0);
            d = 16'($urandom);
            wr(a, d);
            rd(a, (a < 4) ? regs_m[a] : 16'h0000);
            src_req_in <= 19'($urandom);
            repeat (2) @(posedge clk_in);
            #1;
            check({12'h000, level_req_out}, {12'h000, exp_levels(src_req_in)});
        end
        // Clock enable low holds the read reply and drops a write
        @(posedge clk_in);
        rd_en_in <= 1'b1;
        addr_in <= 5'h00;
        @(posedge clk_in);
        rd_en_in <= 1'b0;
        ce_in <= 1'b0;
        wr_en_in <= 1'b1;
        wr_data_in <= ~regs_m[0];
        repeat (2) @(posedge clk_in);
        wr_en_in <= 1'b0;
        ce_in <= 1'b1;
        #1;
        check(rd_data_out, regs_m[0]);
        for (int r = 0; r < 4; r++) rd(r, regs_m[r]);
        // Reset in mid-run clears every field again
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        for (int r = 0; r < 4; r++) regs_m[r] = 16'h0000;
        #1;
        check({12'h000, level_req_out}, 16'h0000);
        for (int r = 0; r < 4; r++) rd(r, 16'h0000);
        final_report();
    end
endmodule
